/* File: rtl/isf_input_select_fault_status.sv */
`timescale 1ns/1ps
// Overview of operation
// RQ1: Active input comes from select pins or a register field.
// RQ2: A configuration bit chooses pins or register as the selection source.
// RQ3: Select 00,01,10 pick clock inputs 0,1,2; 11 picks crystal pins.
// RQ4: Undriven select pins read one, so default selection is crystal.
// RQ5: A setting picks crystal oscillator or external clock on crystal pins.
// RQ6: External clock mode switches off crystal load capacitors.
// RQ7: Crystal path predivider allows external clocks above 54 MHz.
// RQ8: Monitor signal loss on all inputs and feedback, and PLL unlock.
// RQ9: Live monitor states are readable; unlock also drives its own pin.
// RQ10: Every status bit has a separate sticky flag bit.
// RQ11: Sticky flag stays set until software clears it.
// RQ12: Writing zero to a flag bit clears that flag.
// RQ13: Interrupt pin asserts on any unmasked status change.
// RQ14: Each source has a mask bit that blocks its interrupt.
// RQ15: Interrupt releases when the causing flags are cleared.
// RQ16: Precision grade disables clock inputs; crystal reference only.
// RQ17: Interrupt and unlock pins are active low; set beats clear.
// RQ18: Register control works only after initialization completes; the code applies cfg.precision_grade before that too.
module isf_input_select_fault_status (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Initialization done from the defaults loader
    input wire logic init_done,
    // Select pins, already resolved with their pull-ups
    input wire logic [1:0] in_sel_pins,
    // Configuration from the serial register file
    input wire isf_pkg::isf_cfg_s cfg,
    input wire logic [isf_pkg::NUM_SRC-1:0] mask,
    input wire logic flag_wr,
    input wire logic [isf_pkg::NUM_SRC-1:0] flag_wr_data,
    // Raw monitor inputs
    input wire logic [isf_pkg::NUM_SRC-1:0] monitor_raw,
    // Controls to the analog input stage
    output isf_pkg::isf_ctl_s ctl,
    // Status readback
    output logic [isf_pkg::NUM_SRC-1:0] status_live,
    output logic [isf_pkg::NUM_SRC-1:0] sticky_flag,
    output logic ready,
    // Fault pins
    output logic irq_pin_n,
    output logic lock_loss_pin_n
);

    isf_pkg::isf_state_e state_q;
    isf_pkg::isf_state_e state_d;
    isf_pkg::isf_ctl_s ctl_q;
    isf_pkg::isf_ctl_s ctl_d;
    logic [isf_pkg::NUM_SRC-1:0] status_q;
    logic [isf_pkg::NUM_SRC-1:0] flag_q;
    logic [isf_pkg::NUM_SRC-1:0] flag_d;
    logic [isf_pkg::NUM_SRC-1:0] mask_q;
    logic [isf_pkg::NUM_SRC-1:0] changed;
    logic irq_q;
    wire logic reg_ok;
    wire isf_pkg::isf_sel_e pin_sel;
    wire isf_pkg::isf_sel_e chosen_sel;
    wire isf_pkg::isf_sel_e final_sel;
    wire logic ext_clock;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            isf_pkg::ISF_ST_INIT: begin
                if (init_done) begin
                    state_d = isf_pkg::ISF_ST_READY;
                end
            end
            isf_pkg::ISF_ST_READY: begin
                state_d = isf_pkg::ISF_ST_READY;
            end
            default: begin
                state_d = isf_pkg::ISF_ST_INIT;
            end
        endcase
    end

    // Register control, except the precision grade bit, is ignored until the loader has finished. [RQ18]
    assign reg_ok = (state_q == isf_pkg::ISF_ST_READY);

    // Pins arrive resolved: an open pin is already one, giving crystal. [RQ4]
    assign pin_sel = isf_pkg::isf_sel_e'(in_sel_pins);
    // Source chosen by the configuration bit. [RQ1] [RQ2]
    assign chosen_sel = (reg_ok && cfg.sel_from_reg) ? cfg.sel_reg : pin_sel;
    // Precision grade forces the crystal and shuts the clock inputs. [RQ16]
    assign final_sel = cfg.precision_grade ? isf_pkg::ISF_SEL_XTAL : chosen_sel;
    // Precision grade must run a real crystal, never an external clock.
    assign ext_clock = reg_ok && cfg.xtal_ext_clock && !cfg.precision_grade;

    always_comb begin
        ctl_d.active_sel = final_sel; // [RQ3]
        ctl_d.osc_enable = !ext_clock; // [RQ5]
        ctl_d.load_caps_enable = !ext_clock; // [RQ6]
        ctl_d.prediv = reg_ok ? cfg.prediv : '0; // [RQ7]
        ctl_d.in_path_enable = !cfg.precision_grade; // [RQ16]
    end

    // Any live status edge once ready is an event for the sticky flags. [RQ8]
    assign changed = monitor_raw ^ status_q;

    // A fault on the same edge as a clear write keeps the flag set. [RQ11] [RQ12] [RQ17]
    always_comb begin
        flag_d = flag_q;
        if (reg_ok && flag_wr) begin
            flag_d = flag_q & flag_wr_data;
        end
        flag_d = flag_d | (changed & {isf_pkg::NUM_SRC{reg_ok}});
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= isf_pkg::ISF_ST_INIT;
            ctl_q <= '{active_sel: isf_pkg::ISF_SEL_XTAL, osc_enable: 1'b1,
                       load_caps_enable: 1'b1, prediv: '0, in_path_enable: 1'b1};
            status_q <= isf_pkg::STATUS_RST;
            flag_q <= isf_pkg::FLAG_RST;
            mask_q <= isf_pkg::MASK_RST;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctl_q <= ctl_d;
            status_q <= monitor_raw; // [RQ8]
            flag_q <= flag_d; // [RQ10]
            if (reg_ok) begin
                mask_q <= mask;
            end
            // Flags drive the pin, so clearing them releases it. [RQ13] [RQ14] [RQ15]
            irq_q <= |(flag_d & ~mask_q);
        end
    end

    assign ctl = ctl_q;
    // Live bits are gated until ready so reads before init show no faults. [RQ9]
    assign status_live = reg_ok ? status_q : isf_pkg::STATUS_RST;
    assign sticky_flag = flag_q;
    assign ready = reg_ok;
    assign irq_pin_n = !irq_q; // [RQ17]
    assign lock_loss_pin_n = !status_q[isf_pkg::SRC_LOL]; // [RQ9] [RQ17]

endmodule // isf_input_select_fault_status

/* File: rtl/isf_pkg.sv */
package isf_pkg;

    // Status sources: four signal-loss monitors, feedback loss and PLL unlock.
    localparam int NUM_SRC = 6;
    localparam int SRC_LOS_IN0 = 0;
    localparam int SRC_LOS_IN1 = 1;
    localparam int SRC_LOS_IN2 = 2;
    localparam int SRC_LOS_XTAL = 3;
    localparam int SRC_LOS_FB = 4;
    localparam int SRC_LOL = 5;

    localparam int PREDIV_W = 2;

    // Reset values of the configuration held by the block.
    localparam logic [5:0] MASK_RST = 6'h3f;
    localparam logic [5:0] FLAG_RST = 6'h00;
    localparam logic [5:0] STATUS_RST = 6'h00;
    localparam logic [1:0] SEL_RST = 2'h3;

    typedef enum logic [1:0] {
        ISF_SEL_IN0 = 2'b00,
        ISF_SEL_IN1 = 2'b01,
        ISF_SEL_IN2 = 2'b10,
        ISF_SEL_XTAL = 2'b11
    } isf_sel_e;

    typedef enum logic [1:0] {
        ISF_ST_INIT = 2'b00,
        ISF_ST_READY = 2'b01
    } isf_state_e;

    typedef struct packed {
        logic sel_from_reg;
        isf_sel_e sel_reg;
        logic xtal_ext_clock;
        logic [PREDIV_W-1:0] prediv;
        logic precision_grade;
    } isf_cfg_s;

    typedef struct packed {
        isf_sel_e active_sel;
        logic osc_enable;
        logic load_caps_enable;
        logic [PREDIV_W-1:0] prediv;
        logic in_path_enable;
    } isf_ctl_s;

endpackage

/* File: testbench/isf_checker.sv */
`timescale 1ns/1ps
module isf_checker (
    // Inputs of the block
    input wire logic clock,
    input wire logic rst_n,
    input wire logic init_done,
    input wire logic [1:0] in_sel_pins,
    input wire isf_pkg::isf_cfg_s cfg,
    input wire logic [5:0] mask,
    input wire logic flag_wr,
    input wire logic [5:0] flag_wr_data,
    input wire logic [5:0] monitor_raw,
    // Outputs of the block
    input wire isf_pkg::isf_ctl_s ctl,
    input wire logic [5:0] status_live,
    input wire logic [5:0] sticky_flag,
    input wire logic ready,
    input wire logic irq_pin_n,
    input wire logic lock_loss_pin_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire [5:0] chg = monitor_raw ^ status_live;
    sequence chg_s; ready && chg != 6'h00; endsequence
    flag_set_a: assert property (chg_s |=>
        (sticky_flag & $past(chg)) == $past(chg)) else $error("Flag missed a change.");
    flag_hold_a: assert property (ready && !flag_wr |=>
        (sticky_flag & $past(sticky_flag)) == $past(sticky_flag)) else $error("Flag lost.");
    flag_clear_a: assert property (ready && flag_wr && chg == 6'h00 |=>
        sticky_flag == ($past(sticky_flag) & $past(flag_wr_data))) else $error("Bad clear.");
    irq_idle_a: assert property (sticky_flag == 6'h00 |-> irq_pin_n) else $error("Irq.");
    lock_pin_a: assert property (ready |-> lock_loss_pin_n != status_live[5])
        else $error("Lol.");
    osc_mode_a: assert property (ready && cfg.xtal_ext_clock && !cfg.precision_grade |=>
        !ctl.osc_enable) else $error("Oscillator mode.");
    pin_sel_a: assert property (!cfg.sel_from_reg && !cfg.precision_grade |=>
        ctl.active_sel == $past(in_sel_pins)) else $error("Pin select.");
    ext_clk_a: assert property (ready && cfg.xtal_ext_clock && !cfg.precision_grade |=>
        !ctl.load_caps_enable && ctl.prediv == $past(cfg.prediv)) else $error("Ext clock.");
    grade_lock_a: assert property (cfg.precision_grade |=> !ctl.in_path_enable &&
        ctl.active_sel == isf_pkg::ISF_SEL_XTAL) else $error("Grade.");
    ready_rise_a: assert property (init_done && !ready |=> ready) else $error("Ready.");
endmodule // isf_checker
bind isf_input_select_fault_status isf_checker i_chk (.*);

/* File: testbench/isf_host.sv */
`timescale 1ns/1ps
module isf_host (
    // Requests from the bench
    input wire logic clock,
    input wire logic req,
    input wire logic [5:0] req_data,
    // Flag write port
    output logic flag_wr = 1'b0,
    output logic [5:0] flag_wr_data = 6'h00
);
    // Idle data keeps flipping so a stale value cannot pass for a write.
    always @(negedge clock) begin
        flag_wr <= req;
        flag_wr_data <= req ? req_data : ~flag_wr_data;
    end
endmodule // isf_host

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0, rst_n = 1'b0, init_done = 1'b0, req = 1'b0;
    logic flag_wr, ready, irq_pin_n, lock_loss_pin_n;
    logic [1:0] in_sel_pins = 2'h3;
    logic [5:0] mask = 6'h3f, monitor_raw = 6'h00, req_data = 6'h00;
    logic [5:0] flag_wr_data, status_live, sticky_flag;
    isf_pkg::isf_cfg_s cfg = '0;
    isf_pkg::isf_ctl_s ctl;
    int n_errors = 0, num_checks = 0;
    always #2 clock = ~clock;
    isf_input_select_fault_status i_dut (.*);
    isf_host i_host (.*);
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        step(20);
        chk("irq", irq_pin_n, 8'h1);
        rst_n = 1'b1;
        cfg.sel_from_reg = 1'b1;
        cfg.sel_reg = isf_pkg::ISF_SEL_IN1;
        step(2);
        chk("sel early", ctl.active_sel, 8'h3);
        chk("ready early", ready, 8'h0);
        init_done = 1'b1;
        step(2);
        chk("sel reg", ctl.active_sel, 8'h1);
        cfg.sel_from_reg = 1'b0;
        for (int i = 0; i < 4; i++) begin
            in_sel_pins = i[1:0];
            step(2);
            chk("sel pin", ctl.active_sel, i[1:0]);
        end
        cfg.xtal_ext_clock = 1'b1;
        cfg.prediv = 2'h2;
        in_sel_pins = 2'h0;
        step(2);
        chk("caps", ctl.load_caps_enable, 8'h0);
        chk("prediv", ctl.prediv, 8'h2);
        chk("osc", ctl.osc_enable, 8'h0);
        cfg.precision_grade = 1'b1;
        step(2);
        chk("grade sel", ctl.active_sel, 8'h3);
        chk("in path", ctl.in_path_enable, 8'h0);
        cfg = '0;
        mask = 6'h1f;
        monitor_raw = 6'h01;
        step(3);
        chk("masked irq", irq_pin_n, 8'h1);
        monitor_raw = 6'h21;
        step(3);
        chk("lol pin", lock_loss_pin_n, 8'h0);
        chk("status", status_live, 8'h21);
        chk("irq", irq_pin_n, 8'h0);
        monitor_raw = 6'h00;
        step(3);
        chk("flags", sticky_flag, 8'h21);
        req_data = 6'h1f;
        req <= 1'b1;
        step(1);
        req <= 1'b0;
        step(3);
        chk("cleared", sticky_flag, 8'h01);
        chk("irq off", irq_pin_n, 8'h1);
        req_data = 6'h00;
        req <= 1'b1;
        step(1);
        monitor_raw = 6'h20;
        req <= 1'b0;
        step(3);
        chk("set wins", sticky_flag, 8'h20);
        chk("irq again", irq_pin_n, 8'h0);
        print_verdict();
    end
    initial begin
        #2000;
        n_errors++;
        print_verdict();
    end
endmodule // tb_top
